// >>> src/sia_defs.vh
// Register offsets, field positions, reset values and timing counts of the interrupt aggregator.
`ifndef SIA_DEFS_VH
`define SIA_DEFS_VH

`define SIA_ADDR_W            12
`define SIA_ADDR_CFG          12'h054
`define SIA_ADDR_STS          12'h058
`define SIA_ADDR_EN           12'h05C
`define SIA_ADDR_EV_STS       12'h060
`define SIA_ADDR_EV_MASK      12'h064

`define SIA_CFG_PUSHPULL      0
`define SIA_CFG_CLK_SEL       1
`define SIA_CFG_POL           4
`define SIA_CFG_LINE_EN       8
`define SIA_CFG_REQ           12
`define SIA_CFG_DEAS_BUSY     13
`define SIA_CFG_DEAS_LSB      24
`define SIA_CFG_DEAS_MSB      31
`define SIA_CFG_RESET         32'h0000_0000

`define SIA_SRC_ECAT          0
`define SIA_SRC_PME           1
`define SIA_SRC_PHY_A         2
`define SIA_SRC_PHY_B         3
`define SIA_SRC_GPT           4
`define SIA_SRC_SOFT          5
`define SIA_SRC_READY         6
`define SIA_SRC_W             7
`define SIA_EN_RESET          7'h00

`define SIA_EV_ASSERT         0
`define SIA_EV_DEAS_DONE      1
`define SIA_EV_W              2
`define SIA_EV_MASK_RESET     2'h0

`define SIA_CLK_PERIOD_NS     5
`define SIA_DEAS_UNIT_NS      10000
`define SIA_DEAS_UNIT_CYC     ((`SIA_DEAS_UNIT_NS + `SIA_CLK_PERIOD_NS - 1) / `SIA_CLK_PERIOD_NS)
`define SIA_DEAS_W            8

`endif

// >>> src/sia_flag.v
// Sticky flag whose hardware set wins over a clear in the same cycle.
`default_nettype none

module sia_flag (
    input  wire ref_clk,
    input  wire resetn,
    input  wire set,
    input  wire clr,
    output reg  q
);

    always @(posedge ref_clk) begin
        if (!resetn) begin
            q <= 1'b0;
        end else if (set) begin
            q <= 1'b1;
        end else if (clr) begin
            q <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> src/sia_deas_timer.v
// De-assertion interval timer counting whole units of a prescaled time base.
`default_nettype none

module sia_deas_timer #(
    parameter UNIT_CYC = 2000,
    parameter W        = 8
) (
    input  wire         ref_clk,
    input  wire         resetn,
    input  wire         start,
    input  wire [W-1:0] interval,
    output wire         busy,
    output reg          done
);

    reg [15:0]  pre_reg;
    reg [W-1:0] cnt_reg;
    wire        tick;

    assign tick = (pre_reg == UNIT_CYC[15:0] - 16'h0001);
    assign busy = (cnt_reg != {W{1'b0}});

    always @(posedge ref_clk) begin
        if (!resetn) begin
            pre_reg <= 16'h0000;
            cnt_reg <= {W{1'b0}};
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                // A zero interval loads nothing, so the timer stays idle.
                pre_reg <= 16'h0000;
                cnt_reg <= interval;
            end else if (busy) begin
                pre_reg <= tick ? 16'h0000 : pre_reg + 16'h0001;
                if (tick) begin
                    cnt_reg <= cnt_reg - {{(W-1){1'b0}}, 1'b1};
                    done    <= (cnt_reg == {{(W-1){1'b0}}, 1'b1});
                end
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/sia_top.v
// System interrupt aggregator: top status, enable and line configuration behind APB.
//
// Design decisions made here: the APB slave port and the register addresses.
`include "sia_defs.vh"
`default_nettype none

// What this block does
// [R1] All internal sources merge into one host interrupt line, each maskable.
// [R2] Software sets line driver type, active polarity and minimum inactive interval.
// [R3] An open-drain driver option lets several devices share one line.
// [R4] Top status bits gated by matching enable bits form the host interrupt.
// [R5] Timer, software and ready sources live fully in top status and enable.
// [R6] Fieldbus, power and transceiver sources show only a summary bit here.
// [R7] Summary bits stay set until the host clears the event at its source.
// [R8] A line configuration bit enables driving the pin, apart from status and enable.
// [R9] A de-assertion timer holds the line inactive while it runs.
// [R10] An all-zero interval field disables the de-assertion timer.
// [R11] The interval starts whenever the line goes inactive, for any reason.
// [R12] The software flag sets only on a rising edge of its enable bit.
// [R13] Writing one clears the ready status bit; writing zero leaves it.
// [R14] The line is active only while the line enable bit is set.
// [R15] Clock select routes the crystal clock onto the pin for debug.
// [R16] The interval counts in a fixed unit derived from the system clock.
module sia_top #(
    parameter DEAS_UNIT_CYC = `SIA_DEAS_UNIT_CYC
) (
    input  wire                   ref_clk,
    input  wire                   resetn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`SIA_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire                   ecat_irq_in,
    input  wire                   pme_irq_in,
    input  wire                   phy_a_irq_in,
    input  wire                   phy_b_irq_in,
    input  wire                   gpt_wrap_pulse,
    input  wire                   device_ready,
    input  wire                   xtal_clk_in,
    output reg                    irq_pin_out,
    output reg                    irq_pin_oe,
    output reg                    evt_irq
);

    reg                    line_en_reg;
    reg                    pushpull_reg;
    reg                    clk_sel_reg;
    reg                    pol_reg;
    reg [`SIA_DEAS_W-1:0]  deassert_interval_field_reg;
    reg [`SIA_SRC_W-1:0]   soft_event_enable_reg;
    reg [`SIA_EV_W-1:0]    ev_mask_reg;
    reg                    asserted_reg;
    reg                    ready_d_reg;

    reg                    asserted_next;
    reg                    pin_out_next;
    reg                    pin_oe_next;
    reg [31:0]             rd_data;
    reg                    rd_hit;

    wire                   gpt_q;
    wire                   soft_event_flag;
    wire                   ready_q;
    wire [`SIA_EV_W-1:0]   ev_q;
    wire                   deas_busy;
    wire                   deas_done;
    wire                   deas_start;
    wire [`SIA_SRC_W-1:0]  top_interrupt_status;
    wire                   irq_req;
    wire                   acc;
    wire                   wr_done;
    wire                   rd_done;
    wire                   wr_cfg;
    wire                   wr_sts;
    wire                   wr_en;
    wire                   wr_ev_mask;
    wire                   rd_ev_sts;
    wire                   soft_set;
    wire                   ready_rise;
    wire                   line_rise;
    wire [`SIA_SRC_W-1:0]  sts_clr;
    wire [`SIA_EV_W-1:0]   ev_clr;

    // Transfers finish on the edge that samples pready high, one wait cycle after setup.
    assign acc     = psel & penable;
    assign wr_done = acc & pready & pwrite;
    assign rd_done = acc & pready & ~pwrite;

    assign wr_cfg     = wr_done & (paddr == `SIA_ADDR_CFG);
    assign wr_sts     = wr_done & (paddr == `SIA_ADDR_STS);
    assign wr_en      = wr_done & (paddr == `SIA_ADDR_EN);
    assign wr_ev_mask = wr_done & (paddr == `SIA_ADDR_EV_MASK);
    assign rd_ev_sts  = rd_done & (paddr == `SIA_ADDR_EV_STS);

    // Summary bits follow their sub-module request level and cannot be cleared here.
    assign top_interrupt_status = {ready_q,
                                   soft_event_flag,
                                   gpt_q,
                                   phy_b_irq_in,
                                   phy_a_irq_in,
                                   pme_irq_in,
                                   ecat_irq_in}; // [R6] [R7]

    assign irq_req = (|(top_interrupt_status & soft_event_enable_reg))
                     & line_en_reg; // [R1] [R4] [R14]

    assign soft_set   = wr_en & pwdata[`SIA_SRC_SOFT]
                        & ~soft_event_enable_reg[`SIA_SRC_SOFT]; // [R12]
    assign ready_rise = device_ready & ~ready_d_reg;
    assign line_rise  = asserted_next & ~asserted_reg;

    // Write-one-to-clear strobes; the summary bits of this word have no clear and ignore them.
    assign sts_clr = {`SIA_SRC_W{wr_sts}} & pwdata[`SIA_SRC_W-1:0];

    // Only bits the host has already been shown are cleared, so a fresh event is never lost.
    assign ev_clr = {`SIA_EV_W{rd_ev_sts}} & prdata[`SIA_EV_W-1:0];

    // Any fall of the line, whatever caused it, restarts the interval.
    assign deas_start = asserted_reg & ~asserted_next; // [R11]

    sia_flag u_gpt_flag (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set     (gpt_wrap_pulse),
        .clr     (sts_clr[`SIA_SRC_GPT]), // [R5]
        .q       (gpt_q)
    );

    sia_flag u_soft_flag (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set     (soft_set),
        .clr     (sts_clr[`SIA_SRC_SOFT]), // [R5]
        .q       (soft_event_flag)
    );

    sia_flag u_ready_flag (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set     (ready_rise),
        .clr     (sts_clr[`SIA_SRC_READY]), // [R13]
        .q       (ready_q)
    );

    sia_flag u_ev_assert (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set     (line_rise),
        .clr     (ev_clr[`SIA_EV_ASSERT]),
        .q       (ev_q[`SIA_EV_ASSERT])
    );

    sia_flag u_ev_deas (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .set     (deas_done),
        .clr     (ev_clr[`SIA_EV_DEAS_DONE]),
        .q       (ev_q[`SIA_EV_DEAS_DONE])
    );

    sia_deas_timer #(
        .UNIT_CYC (DEAS_UNIT_CYC),
        .W        (`SIA_DEAS_W)
    ) u_deas (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .start    (deas_start), // [R9] [R10] [R16]
        .interval (deassert_interval_field_reg),
        .busy     (deas_busy),
        .done     (deas_done)
    );

    always @* begin
        // The line may not rise again while the interval runs.
        asserted_next = irq_req & ~deas_busy; // [R9]
        pin_out_next  = 1'b0;
        pin_oe_next   = 1'b0;
        if (clk_sel_reg) begin
            // Push-pull is the sensible choice here; open-drain would round the clock edges.
            pin_out_next = xtal_clk_in; // [R15]
            pin_oe_next  = 1'b1;
        end else if (line_en_reg) begin // [R8]
            if (pushpull_reg) begin
                pin_out_next = asserted_next ? pol_reg : ~pol_reg; // [R2]
                pin_oe_next  = 1'b1;
            end else begin
                pin_out_next = pol_reg; // [R3]
                pin_oe_next  = asserted_next;
            end
        end
    end

    always @* begin
        rd_data = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr)
            `SIA_ADDR_CFG: begin
                rd_data[`SIA_CFG_PUSHPULL]  = pushpull_reg;
                rd_data[`SIA_CFG_CLK_SEL]   = clk_sel_reg;
                rd_data[`SIA_CFG_POL]       = pol_reg;
                rd_data[`SIA_CFG_LINE_EN]   = line_en_reg;
                rd_data[`SIA_CFG_REQ]       = asserted_reg;
                rd_data[`SIA_CFG_DEAS_BUSY] = deas_busy;
                rd_data[`SIA_CFG_DEAS_MSB:`SIA_CFG_DEAS_LSB] = deassert_interval_field_reg;
            end
            `SIA_ADDR_STS: begin
                rd_data[`SIA_SRC_W-1:0] = top_interrupt_status;
            end
            `SIA_ADDR_EN: begin
                rd_data[`SIA_SRC_W-1:0] = soft_event_enable_reg;
            end
            `SIA_ADDR_EV_STS: begin
                rd_data[`SIA_EV_W-1:0] = ev_q;
            end
            `SIA_ADDR_EV_MASK: begin
                rd_data[`SIA_EV_W-1:0] = ev_mask_reg;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            pready <= 1'b0;
        end else begin
            pready <= acc & ~pready;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (acc & ~pready) begin
            // Read data is frozen here so a read-clear drops only bits that were seen.
            prdata  <= pwrite ? 32'h0000_0000 : rd_data;
            pslverr <= ~rd_hit;
        end else begin
            // Both fall with pready, so nothing stale is shown outside the answer cycle.
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            pushpull_reg                <= 1'b0;
            clk_sel_reg                 <= 1'b0;
            pol_reg                     <= 1'b0;
            line_en_reg                 <= 1'b0;
            deassert_interval_field_reg <= {`SIA_DEAS_W{1'b0}};
        end else if (wr_cfg) begin // [R2]
            pushpull_reg                <= pwdata[`SIA_CFG_PUSHPULL];
            clk_sel_reg                 <= pwdata[`SIA_CFG_CLK_SEL];
            pol_reg                     <= pwdata[`SIA_CFG_POL];
            line_en_reg                 <= pwdata[`SIA_CFG_LINE_EN];
            deassert_interval_field_reg <= pwdata[`SIA_CFG_DEAS_MSB:`SIA_CFG_DEAS_LSB];
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            soft_event_enable_reg <= `SIA_EN_RESET;
        end else if (wr_en) begin
            soft_event_enable_reg <= pwdata[`SIA_SRC_W-1:0]; // [R4]
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            ev_mask_reg <= `SIA_EV_MASK_RESET;
        end else if (wr_ev_mask) begin
            ev_mask_reg <= pwdata[`SIA_EV_W-1:0];
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            asserted_reg <= 1'b0;
            ready_d_reg  <= 1'b0;
        end else begin
            asserted_reg <= asserted_next;
            ready_d_reg  <= device_ready;
        end
    end

    // The pin is driven from flops so it never glitches while the source terms settle.
    always @(posedge ref_clk) begin
        if (!resetn) begin
            irq_pin_out <= 1'b0;
            irq_pin_oe  <= 1'b0;
        end else begin
            irq_pin_out <= pin_out_next;
            irq_pin_oe  <= pin_oe_next;
        end
    end

    always @(posedge ref_clk) begin
        if (!resetn) begin
            evt_irq <= 1'b0;
        end else begin
            evt_irq <= |(ev_q & ev_mask_reg);
        end
    end

endmodule

`default_nettype wire

// >>> bench/sia_chk.sv
// Port-level assertions for the interrupt aggregator.
`include "sia_defs.vh"
`default_nettype none
module sia_chk #(
    parameter DEAS_UNIT_CYC = 4
) (
    input wire logic                   ref_clk,
    input wire logic                   resetn,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [`SIA_ADDR_W-1:0] paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   irq_pin_out,
    input wire logic                   irq_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] cfg_reg;
    logic [6:0]  en_reg;
    logic [1:0]  age_reg;
    wire         wr   = psel && penable && pready && pwrite;
    wire         hit  = wr && (paddr == `SIA_ADDR_CFG || paddr == `SIA_ADDR_EN);
    wire         pp   = cfg_reg[`SIA_CFG_PUSHPULL];
    wire         cs   = cfg_reg[`SIA_CFG_CLK_SEL];
    wire         pol  = cfg_reg[`SIA_CFG_POL];
    wire         len  = cfg_reg[`SIA_CFG_LINE_EN];
    wire         calm = age_reg == 2'h3;
    wire         act  = !cs && irq_pin_oe && (!pp || irq_pin_out == pol);
    wire         ivl  = cfg_reg[`SIA_CFG_DEAS_MSB:`SIA_CFG_DEAS_LSB] != 8'h00;
    // The age count hides the pin pipeline, so a fresh write never trips a check.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cfg_reg <= 32'h0000_0000;
            en_reg  <= 7'h00;
            age_reg <= 2'h0;
        end else begin
            if (wr && paddr == `SIA_ADDR_CFG) begin
                cfg_reg <= pwdata;
            end
            if (wr && paddr == `SIA_ADDR_EN) begin
                en_reg <= pwdata[6:0];
            end
            age_reg <= hit ? 2'h0 : age_reg + {1'b0, !calm};
        end
    end
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stayed high");
    chk_ready_lag: assert property ($rose(penable) && psel |=> pready)
        else $error("pready late");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_line_off: assert property (calm && !len && !cs |-> !irq_pin_oe)
        else $error("pin driven while line off");
    chk_od_level: assert property (calm && !pp && !cs && irq_pin_oe |-> irq_pin_out == pol)
        else $error("open-drain level wrong");
    chk_pp_drive: assert property (calm && pp && len && !cs |-> irq_pin_oe)
        else $error("push-pull pin released");
    chk_en_gate: assert property (calm && en_reg == 7'h00 |-> !act)
        else $error("line active with nothing enabled");
    chk_clk_oe: assert property (calm && cs |-> irq_pin_oe)
        else $error("clock test pin released");
    chk_hold_low: assert property (calm && $fell(act) && ivl |=> !act [*3])
        else $error("line reasserted inside interval");
    cov_gap: cover property ($fell(act) && ivl);
    cov_err: cover property (pslverr);
    cov_clk: cover property (calm && cs && irq_pin_oe);
endmodule

bind sia_top sia_chk #(.DEAS_UNIT_CYC(DEAS_UNIT_CYC)) sia_chk_i (
    .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .pslverr, .irq_pin_out, .irq_pin_oe
);
`default_nettype wire

// >>> bench/sia_host.sv
// Far-side model: sub-module event flags and the resolved shared interrupt wire.
`default_nettype none
module sia_host (
    input  wire logic       ref_clk,
    input  wire logic       resetn,
    input  wire logic [3:0] raise,
    input  wire logic [3:0] clear,
    input  wire logic       irq_pin_out,
    input  wire logic       irq_pin_oe,
    output var  logic [3:0] src_reg,
    output wire logic       irq_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pull-up holds the shared line high whenever nobody drives it.
    assign irq_wire = irq_pin_oe ? irq_pin_out : 1'b1;
    // An event stays pending until the host clears it in its own sub-module.
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            src_reg <= 4'h0;
        end else begin
            src_reg <= (src_reg & ~clear) | raise;
        end
    end
endmodule
`default_nettype wire

// >>> bench/sia_top_bench.sv
// Self-checking bench for the interrupt aggregator.
`include "sia_defs.vh"
`default_nettype none
module sia_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int U   = 4;
    localparam int GAP = 2 * U - 2;
    logic        ref_clk        = 1'b0;
    logic        resetn         = 1'b0;
    logic        psel           = 1'b0;
    logic        penable        = 1'b0;
    logic        pwrite         = 1'b0;
    logic [11:0] paddr          = 12'h000;
    logic [31:0] pwdata         = 32'h0000_0000;
    logic        gpt_wrap_pulse = 1'b0;
    logic        device_ready   = 1'b0;
    logic        xtal_clk_in    = 1'b0;
    logic [3:0]  raise          = 4'h0;
    logic [3:0]  clear          = 4'h0;
    logic [7:0]  ivs [2]        = '{8'h00, 8'h02};
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_pin_out;
    logic        irq_pin_oe;
    logic        evt_irq;
    logic        irq_wire;
    logic [3:0]  src_reg;
    logic [31:0] rd;
    logic        err;
    int          fails          = 0;
    int          tests_run      = 0;
    int          n;
    always #2.5 ref_clk = ~ref_clk;
    sia_top #(.DEAS_UNIT_CYC(U)) sia_top_i (
        .ref_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ecat_irq_in(src_reg[0]), .pme_irq_in(src_reg[1]),
        .phy_a_irq_in(src_reg[2]), .phy_b_irq_in(src_reg[3]), .gpt_wrap_pulse,
        .device_ready, .xtal_clk_in, .irq_pin_out, .irq_pin_oe, .evt_irq
    );
    sia_host sia_host_i (
        .ref_clk, .resetn, .raise, .clear, .irq_pin_out, .irq_pin_oe, .src_reg, .irq_wire
    );
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // Every transfer is followed by one idle cycle, so no strobe is driven twice in a step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd  = prdata;
        err = pslverr;
        if (k == 20) fails++;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, rd, exp);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask
    task automatic pulse();
        gpt_wrap_pulse <= 1'b1;
        @(posedge ref_clk);
        gpt_wrap_pulse <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        complete_run;
    end
    initial begin
        cyc(20);
        resetn <= 1'b1;
        cyc(1);
        rdchk("cfg", `SIA_ADDR_CFG, `SIA_CFG_RESET);
        rdchk("en", `SIA_ADDR_EN, 32'h0000_0000);
        rdchk("hole", 12'h000, 32'h0000_0000);
        chk("hole err", {31'h0, err}, 32'h1);
        $display("reset test done");
        wr(`SIA_ADDR_CFG, 32'h0000_0100);
        wr(`SIA_ADDR_EN, 32'h0000_0020);
        rdchk("soft", `SIA_ADDR_STS, 32'h0000_0020);
        chk("soft line", {31'h0, irq_wire}, 32'h0);
        wr(`SIA_ADDR_STS, 32'h0000_0020);
        wr(`SIA_ADDR_EN, 32'h0000_0020);
        rdchk("soft kept", `SIA_ADDR_STS, 32'h0000_0000);
        chk("soft off", {31'h0, irq_wire}, 32'h1);
        $display("soft test done");
        device_ready <= 1'b1;
        pulse();
        rdchk("ready", `SIA_ADDR_STS, 32'h0000_0050);
        wr(`SIA_ADDR_STS, 32'h0000_0000);
        rdchk("w0", `SIA_ADDR_STS, 32'h0000_0050);
        wr(`SIA_ADDR_STS, 32'h0000_0050);
        rdchk("w1", `SIA_ADDR_STS, 32'h0000_0000);
        $display("ready test done");
        wr(`SIA_ADDR_EN, 32'h0000_0001);
        raise <= 4'h5;
        cyc(1);
        raise <= 4'h0;
        rdchk("sum", `SIA_ADDR_STS, 32'h0000_0005);
        chk("sum line", {31'h0, irq_wire}, 32'h0);
        wr(`SIA_ADDR_STS, 32'h0000_000F);
        rdchk("sum kept", `SIA_ADDR_STS, 32'h0000_0005);
        clear <= 4'h5;
        cyc(1);
        clear <= 4'h0;
        rdchk("sum gone", `SIA_ADDR_STS, 32'h0000_0000);
        chk("ev masked", {31'h0, evt_irq}, 32'h0);
        wr(`SIA_ADDR_EV_MASK, 32'h0000_0001);
        cyc(2);
        chk("ev raised", {31'h0, evt_irq}, 32'h1);
        apb(1'b0, `SIA_ADDR_EV_STS, 32'h0000_0000);
        chk("ev status", rd & 32'h1, 32'h1);
        cyc(2);
        chk("ev cleared", {31'h0, evt_irq}, 32'h0);
        $display("summary test done");
        wr(`SIA_ADDR_EN, 32'h0000_0010);
        foreach (ivs[i]) begin
            wr(`SIA_ADDR_CFG, {ivs[i], 24'h00_0100});
            pulse();
            cyc(2);
            chk("gap on", {31'h0, irq_wire}, 32'h0);
            wr(`SIA_ADDR_STS, 32'h0000_0010);
            n = 0;
            while (irq_wire !== 1'b1 && n < 50) begin
                @(negedge ref_clk);
                n++;
            end
            n = 0;
            do begin
                @(posedge ref_clk);
                gpt_wrap_pulse <= (n == 0);
                @(negedge ref_clk);
                n++;
            end while (irq_wire === 1'b1 && n < 100);
            @(posedge ref_clk);
            chk("gap", {31'h0, n >= GAP}, {31'h0, ivs[i] != 8'h00});
        end
        $display("interval test done");
        wr(`SIA_ADDR_CFG, 32'h0000_0111);
        cyc(2);
        chk("pp on", {30'h0, irq_pin_oe, irq_pin_out}, 32'h3);
        wr(`SIA_ADDR_EN, 32'h0000_0000);
        cyc(2);
        chk("pp idle", {30'h0, irq_pin_oe, irq_pin_out}, 32'h2);
        wr(`SIA_ADDR_CFG, 32'h0000_0011);
        cyc(2);
        chk("line off", {30'h0, irq_pin_oe, irq_pin_out}, 32'h0);
        wr(`SIA_ADDR_CFG, 32'h0000_0103);
        xtal_clk_in <= 1'b1;
        cyc(3);
        chk("clk hi", {30'h0, irq_pin_oe, irq_pin_out}, 32'h3);
        xtal_clk_in <= 1'b0;
        cyc(3);
        chk("clk lo", {30'h0, irq_pin_oe, irq_pin_out}, 32'h2);
        $display("driver test done");
        complete_run;
    end
endmodule
`default_nettype wire
